// File: testbench/serial_clk_partner.sv
/*
  far-side clock source on the serial clock pin.
  assumes the bench raises run only while the pin is an input.
*/
`timescale 1ns/100ps
`default_nettype none
module serial_clk_partner
(
  input  wire logic clock,
  input  wire logic run,
  output var logic  pin
);
  logic [1:0] cnt_ff = 2'h0;
  initial pin = 1'b1;
  // pin toggles every 4 clocks (8-clock period) while running, held still otherwise
  always @(posedge clock)
  begin
    if (run)
    begin
      cnt_ff <= cnt_ff + 2'h1;
      if (cnt_ff == 2'h3) pin <= ~pin;
    end
  end
endmodule : serial_clk_partner
`default_nettype wire

// File: testbench/serial_port_control_bench.sv
/*
  self-checking bench for the serial port control block.
  assumes avalon-mm access with one wait state and same-clock events.
*/
`timescale 1ns/100ps
`default_nettype none
module serial_port_control_bench
  import serial_port_control_pkg::*;
;
  logic clock = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, baud_tick = 1'b0;
  logic run = 1'b0, pin, waitrequest, tx_run, rx_run, rx_accept, bit_tick, irq;
  logic t_e, r_f, r_e, t_d, pin_out, pin_oe_n;
  logic [4:0]  address = 5'h00;
  logic [31:0] writedata = 32'h0, readdata;
  logic [5:0]  evv = 6'h00;
  logic [1:0]  bcnt = 2'h0;
  logic [7:0]  ticks = 8'h0;
  logic [7:0]  t0, acc = 8'h0;
  logic [3:0]  be = 4'hf;
  logic        pv;
  int mismatches = 0, compares = 0;
  logic [7:0] gate [4] = '{8'h80, 8'h40, 8'h40, 8'h04};
  logic [5:0] evt [4] = '{6'h20, 6'h08, 6'h0a, 6'h10};
  logic [7:0] st [4] = '{8'h01, 8'h02, 8'h04, 8'h10};
  logic [7:0] fm [4] = '{8'h00, 8'h00, 8'h80, 8'h80};
  logic [7:0] cd [4] = '{8'h00, 8'h01, 8'h00, 8'h02};
  logic [7:0] oe [4] = '{8'h01, 8'h00, 8'h00, 8'h01};
  initial forever #5 clock = ~clock;
  // free running 16x tick and bit tick counter
  always @(posedge clock)
  begin
    bcnt <= bcnt + 2'h1;
    baud_tick <= (bcnt == 2'h3);
    if (bit_tick === 1'b1) ticks <= ticks + 8'h1;
    if (rx_accept === 1'b1) acc <= acc + 8'h1;
  end
  serial_port_control i_serial_port_control (.clock(clock), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(be), .readdata(readdata), .waitrequest(waitrequest),
    .baud_tick(baud_tick), .rx_char_done(evv[3]), .rx_mp_bit(evv[2]),
    .rx_frame_bad(evv[1]), .rx_overrun(evv[0]), .tx_data_empty(evv[5]),
    .tx_char_end(evv[4]), .tx_run(tx_run), .rx_run(rx_run),
    .rx_accept(rx_accept), .bit_tick(bit_tick), .tx_empty_irq(t_e),
    .rx_full_irq(r_f), .rx_err_irq(r_e), .tx_done_irq(t_d), .irq(irq),
    .serial_clk_pin_in(pin), .serial_clk_pin_out(pin_out),
    .serial_clk_pin_oe_n(pin_oe_n));
  serial_clk_partner i_serial_clk_partner (.clock(clock), .run(run), .pin(pin));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writedata <= {24'h0, d};
    write <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask : wr
  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    chk(readdata[7:0], e);
    read <= 1'b0;
  endtask : rc
  task automatic ev(input logic [5:0] v);
    @(posedge clock);
    evv <= v;
    @(posedge clock);
    evv <= 6'h00;
    repeat (3) @(posedge clock);
  endtask : ev
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial
  begin
    #200000;
    mismatches++;
    conclude();
  end
  initial
  begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rc(LINE_CONTROL_ADDR, LINE_CONTROL_RESET);
    rc(LINE_FORMAT_ADDR, LINE_FORMAT_RESET);
    rc(EVENT_STATUS_ADDR, {3'h0, EVENT_RESET});
    wr(5'h14, 8'hff);
    rc(5'h14, 8'h00);
    rc(EVENT_CLEAR_ADDR, 8'h00);
    be <= 4'h0;
    wr(LINE_CONTROL_ADDR, 8'h55);
    be <= 4'hf;
    rc(LINE_CONTROL_ADDR, 8'h00);
    wr(LINE_CONTROL_ADDR, 8'hf6);
    rc(LINE_CONTROL_ADDR, 8'hf6);
    chk({6'h0, tx_run, rx_run}, 8'h03);
    wr(LINE_CONTROL_ADDR, 8'h80);
    ev(6'h20);
    rc(EVENT_STATUS_ADDR, 8'h00);
    $display("test registers done");
    wr(EVENT_ENABLE_ADDR, 8'h1f);
    for (int i = 0; i < 4; i++)
    begin
      wr(LINE_CONTROL_ADDR, 8'h30 | gate[i]);
      ev(evt[i]);
      chk({4'h0, t_e, r_f, r_e, t_d}, 8'h08 >> i);
      chk({7'h0, irq}, 8'h01);
      rc(EVENT_STATUS_ADDR, st[i]);
      wr(LINE_CONTROL_ADDR, 8'h30);
      repeat (3) @(posedge clock);
      chk({4'h0, t_e, r_f, r_e, t_d}, 8'h00);
      wr(EVENT_CLEAR_ADDR, 8'h1f);
      rc(EVENT_STATUS_ADDR, 8'h00);
      chk({7'h0, irq}, 8'h00);
    end
    $display("test interrupts done");
    wr(LINE_FORMAT_ADDR, 8'h04);
    wr(LINE_CONTROL_ADDR, 8'h18);
    ev(6'h08);
    rc(EVENT_STATUS_ADDR, 8'h00);
    ev(6'h0c);
    rc(EVENT_STATUS_ADDR, 8'h02);
    rc(LINE_CONTROL_ADDR, 8'h10);
    for (int i = 0; i < 2; i++)
    begin
      wr(EVENT_CLEAR_ADDR, 8'h1f);
      wr(LINE_FORMAT_ADDR, i ? 8'h84 : 8'h00);
      wr(LINE_CONTROL_ADDR, 8'h18);
      ev(6'h08);
      rc(EVENT_STATUS_ADDR, 8'h02);
    end
    wr(EVENT_CLEAR_ADDR, 8'h1f);
    wr(LINE_CONTROL_ADDR, 8'h00);
    ev(6'h08);
    rc(EVENT_STATUS_ADDR, 8'h00);
    chk(acc, 8'h05);
    $display("test address wait done");
    for (int i = 0; i < 4; i++)
    begin
      wr(LINE_FORMAT_ADDR, fm[i]);
      wr(LINE_CONTROL_ADDR, cd[i]);
      repeat (8) @(posedge clock);
      chk({7'h0, pin_oe_n}, oe[i]);
      pv = pin_out;
      repeat (32) @(posedge clock);
      chk({7'h0, pin_out}, {7'h0, ~pv});
    end
    wr(LINE_FORMAT_ADDR, 8'h00);
    wr(LINE_CONTROL_ADDR, {6'h00, CLK_EXTERNAL});
    repeat (8) @(posedge clock);
    t0 = ticks;
    repeat (64) @(posedge clock);
    chk(ticks - t0, 8'h00);
    chk({7'h0, pin_oe_n}, 8'h01);
    run <= 1'b1;
    t0 = ticks;
    repeat (64) @(posedge clock);
    chk(ticks - t0, 8'h07);
    run <= 1'b0;
    $display("test clock source done");
    conclude();
  end
endmodule : serial_port_control_bench
bind serial_port_control serial_port_control_properties i_serial_port_control_properties (
  .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
  .rx_char_done(rx_char_done), .tx_run(tx_run), .rx_run(rx_run),
  .rx_accept(rx_accept), .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq),
  .rx_err_irq(rx_err_irq), .tx_done_irq(tx_done_irq));
`default_nettype wire

// File: testbench/serial_port_control_properties.sv
/*
  port assertions for the serial port control block.
  assumes a bind from the bench top; one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module serial_port_control_properties
  import serial_port_control_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic        waitrequest,
  input wire logic        rx_char_done,
  input wire logic        tx_run,
  input wire logic        rx_run,
  input wire logic        rx_accept,
  input wire logic        tx_empty_irq,
  input wire logic        rx_full_irq,
  input wire logic        rx_err_irq,
  input wire logic        tx_done_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // accepted write to the control word
  sequence s_wr;
    write && !waitrequest && address == LINE_CONTROL_ADDR && byteenable[0];
  endsequence
  property p_wait; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait");
  property p_ack; !waitrequest |=> waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("answer held too long");
  property p_tx; s_wr |=> tx_run == $past(writedata[TX_ON_BIT]); endproperty
  a_tx: assert property (p_tx) else $error("tx_run wrong");
  property p_rx; s_wr |=> rx_run == $past(writedata[RX_ON_BIT]); endproperty
  a_rx: assert property (p_rx) else $error("rx_run wrong");
  property p_tg; s_wr ##0 !writedata[7] |-> ##2 !tx_empty_irq; endproperty
  a_tg: assert property (p_tg) else $error("tx empty request ungated");
  property p_rg; s_wr ##0 !writedata[6] |-> ##2 !(rx_full_irq || rx_err_irq); endproperty
  a_rg: assert property (p_rg) else $error("rx request ungated");
  property p_dg; s_wr ##0 !writedata[2] |-> ##2 !tx_done_irq; endproperty
  a_dg: assert property (p_dg) else $error("tx end request ungated");
  property p_off; rx_char_done && !rx_run |=> !rx_accept; endproperty
  a_off: assert property (p_off) else $error("char kept while rx off");
  property p_acc; rx_accept |-> $past(rx_char_done); endproperty
  a_acc: assert property (p_acc) else $error("accept without char");
  c_wr: cover property (s_wr);
  c_acc: cover property (rx_accept);
  c_tx: cover property (tx_empty_irq);
endmodule : serial_port_control_properties
`default_nettype wire

// File: verilog/clock_source_if.sv
/*
  carrier between the control block and the clock source selector.
  assumes both ends run on the same system clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface clock_source_if;
  logic       sync_mode;   // 1: clock-synchronous
  logic [1:0] src_code;    // clock-select code
  logic       bit_tick;    // pulse: shift core may advance one step
  logic       pin_out;     // driven level of the serial clock pin
  logic       pin_oe_n;    // low while the pin is driven

  modport control (output sync_mode, output src_code,
                   input bit_tick, input pin_out, input pin_oe_n);
  modport selector (input sync_mode, input src_code,
                    output bit_tick, output pin_out, output pin_oe_n);
endinterface : clock_source_if
`default_nettype wire

// File: verilog/clock_source_select.sv
/*
  picks the bit clock source: internal 16x baud tick or the serial clock
  pin, and drives the pin as a clock output where the code asks for it.
  assumes baud_tick is a one-cycle pulse on clock at 16x the bit rate.
*/
`timescale 1ns/100ps
`default_nettype none
module clock_source_select
  import serial_port_control_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      rst,
  input  wire logic      baud_tick,
  input  wire logic      pin_in,
  clock_source_if.selector cs
);

  logic       pin_meta_ff;
  logic       pin_sync_ff;
  logic       pin_last_ff;
  logic [3:0] half_cnt_ff;
  logic       pin_level_ff;
  logic       tick_ff;
  logic       oe_n_ff;
  logic       ext_sel;
  logic       drive_sel;

  // external source only for code 10; drive pin for async 01 or sync 00
  assign ext_sel   = (cs.src_code == CLK_EXTERNAL);
  assign drive_sel = cs.sync_mode ? (cs.src_code == CLK_INTERNAL)
                                  : (cs.src_code == CLK_INTERNAL_OUT);

  // two-flop synchroniser for the pin, then edge history
  // history resets to the idle-high pin level, so no false edge after reset
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
      pin_last_ff <= 1'b1;
    end
    else
    begin
      pin_meta_ff <= pin_in;
      pin_sync_ff <= pin_meta_ff;
      pin_last_ff <= pin_sync_ff;
    end
  end

  // bit-rate clock made from the 16x tick: toggle every half bit
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      half_cnt_ff  <= 4'h0;
      pin_level_ff <= 1'b1;
    end
    else if (baud_tick)
    begin
      if (half_cnt_ff == HALF_BIT_TICKS)
      begin
        half_cnt_ff  <= 4'h0;
        pin_level_ff <= ~pin_level_ff;
      end
      else
        half_cnt_ff <= half_cnt_ff + 4'h1;
    end
  end

  // selected tick; external pin counts on its rising edge
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tick_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end
    else
    begin
      tick_ff <= ext_sel ? (pin_sync_ff & ~pin_last_ff) : baud_tick;
      oe_n_ff <= ~drive_sel;
    end
  end

  assign cs.bit_tick = tick_ff;
  assign cs.pin_out  = pin_level_ff;
  assign cs.pin_oe_n = oe_n_ff;

endmodule : clock_source_select
`default_nettype wire

// File: verilog/serial_port_control.sv
/*
  control word logic of the serial port: avalon-mm register slave, enables,
  interrupt gating, address-wait filtering and clock source selection.
  registers: control word, format word, sticky event status, write-one
  clear and event enable, each in the low byte of its 32-bit word.
  assumes the shift core sits on the same clock and gives one-cycle event
  pulses; the serial clock pin arrives asynchronously.
  assumes software keeps to the legal clock-select codes; reserved codes
  fall back to the internal tick with the pin left undriven.
*/
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module serial_port_control
  import serial_port_control_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // shift core events, same clock
  input  wire logic        baud_tick,
  input  wire logic        rx_char_done,
  input  wire logic        rx_mp_bit,
  input  wire logic        rx_frame_bad,
  input  wire logic        rx_overrun,
  input  wire logic        tx_data_empty,
  input  wire logic        tx_char_end,
  // controls toward the shift core
  output logic             tx_run,
  output logic             rx_run,
  output logic             rx_accept,
  output logic             bit_tick,
  // interrupt requests
  output logic             tx_empty_irq,
  output logic             rx_full_irq,
  output logic             rx_err_irq,
  output logic             tx_done_irq,
  output logic             irq,
  // serial clock pin
  input  wire logic        serial_clk_pin_in,
  output logic             serial_clk_pin_out,
  output logic             serial_clk_pin_oe_n
);

  clock_source_if cs ();

  logic [7:0]          line_control_word_ff;
  logic [7:0]          line_format_word_ff;
  logic [EV_WIDTH-1:0] event_status_ff;
  logic [EV_WIDTH-1:0] event_enable_ff;
  logic [31:0]         readdata_ff;
  logic                waitrequest_ff;
  logic                rx_accept_ff;
  logic                tx_empty_req_ff;
  logic                rx_full_req_ff;
  logic                rx_err_req_ff;
  logic                tx_done_req_ff;
  logic                irq_ff;
  logic                wr_take;
  logic                rd_capture;
  logic                lane0;
  logic                wr_control;
  logic                wr_format;
  logic                wr_clear;
  logic                wr_enable;
  logic                sync_mode;
  logic                filter_on;
  logic                rx_seen;
  logic                rx_kept;
  logic                wait_release;
  logic [EV_WIDTH-1:0] nxt_event_set;
  logic [EV_WIDTH-1:0] nxt_event_clr;
  logic [31:0]         nxt_readdata;
  logic [7:0]          nxt_line_control_word;

  // bus handshake: request answered one cycle after it is first seen
  assign wr_take    = write & ~waitrequest_ff;
  assign rd_capture = read & waitrequest_ff; // read data latched in the wait cycle
  assign lane0      = byteenable[0];

  // write strobes per register; a write without the low lane is ignored
  assign wr_control = wr_take & lane0 & (address == LINE_CONTROL_ADDR);
  assign wr_format  = wr_take & lane0 & (address == LINE_FORMAT_ADDR);
  assign wr_clear   = wr_take & lane0 & (address == EVENT_CLEAR_ADDR);
  assign wr_enable  = wr_take & lane0 & (address == EVENT_ENABLE_ADDR);

  // wait state: high at idle, low for one cycle per request
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      waitrequest_ff <= 1'b1;
    else
      waitrequest_ff <= ~((read | write) & waitrequest_ff);
  end

  // mode decode and address-wait qualification
  assign sync_mode = line_format_word_ff[SYNC_MODE_BIT];
  assign filter_on = line_control_word_ff[ADDR_WAIT_ON_BIT]
                   & line_format_word_ff[MULTI_DROP_ON_BIT]
                   & ~sync_mode;

  // receive qualification: enable first, then the address-wait filter
  assign rx_seen   = rx_char_done & line_control_word_ff[RX_ON_BIT];
  assign rx_kept   = rx_seen & (~filter_on | rx_mp_bit);
  assign wait_release = rx_seen & filter_on & rx_mp_bit;

  // next control word; hardware release of address wait beats a software write
  always_comb
  begin
    nxt_line_control_word = line_control_word_ff;
    if (wr_control)
      nxt_line_control_word = writedata[7:0];
    if (wait_release)
      nxt_line_control_word[ADDR_WAIT_ON_BIT] = 1'b0;
  end

  // control word register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      line_control_word_ff <= LINE_CONTROL_RESET;
    else
      line_control_word_ff <= nxt_line_control_word;
  end

  // format word: mode and multi-drop selection
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      line_format_word_ff <= LINE_FORMAT_RESET;
    else if (wr_format)
      line_format_word_ff <= writedata[7:0];
  end

  // event sources; receive flags only for kept characters
  always_comb
  begin
    nxt_event_set               = '0;
    nxt_event_set[EV_TX_EMPTY]  = tx_data_empty & line_control_word_ff[TX_ON_BIT];
    nxt_event_set[EV_RX_FULL]   = rx_kept & ~rx_frame_bad & ~rx_overrun;
    nxt_event_set[EV_FRAME_ERR] = rx_kept & rx_frame_bad;
    nxt_event_set[EV_OVERRUN]   = rx_kept & rx_overrun;
    nxt_event_set[EV_TX_DONE]   = tx_char_end & line_control_word_ff[TX_ON_BIT];
  end

  // write-one-to-clear mask for the status register
  assign nxt_event_clr = wr_clear ? writedata[EV_WIDTH-1:0]
                                  : '0;

  // sticky status: a set in the clearing cycle wins
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      event_status_ff <= EVENT_RESET;
    else
      event_status_ff <= (event_status_ff & ~nxt_event_clr) | nxt_event_set;
  end

  // interrupt enable register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      event_enable_ff <= EVENT_RESET;
    else if (wr_enable)
      event_enable_ff <= writedata[EV_WIDTH-1:0];
  end

  // read mux; unmapped and write-only addresses read zero
  always_comb
  begin
    nxt_readdata = 32'h0000_0000;
    unique case (address)
      LINE_CONTROL_ADDR: nxt_readdata[7:0] = line_control_word_ff;
      LINE_FORMAT_ADDR:  nxt_readdata[7:0] = line_format_word_ff;
      EVENT_STATUS_ADDR: nxt_readdata[EV_WIDTH-1:0] = event_status_ff;
      EVENT_ENABLE_ADDR: nxt_readdata[EV_WIDTH-1:0] = event_enable_ff;
      default:           nxt_readdata = 32'h0000_0000;
    endcase
  end

  // read data captured while waiting, stands at the answer edge
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      readdata_ff <= 32'h0000_0000;
    else if (rd_capture)
      readdata_ff <= nxt_readdata;
  end

  // transmit-empty request follows its status bit while enabled
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      tx_empty_req_ff <= 1'b0;
    else
      tx_empty_req_ff <= line_control_word_ff[TX_EMPTY_IRQ_ON_BIT]
                       & event_status_ff[EV_TX_EMPTY];
  end

  // receive-full request shares its enable with the error request
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rx_full_req_ff <= 1'b0;
    else
      rx_full_req_ff <= line_control_word_ff[RX_IRQ_ON_BIT]
                      & event_status_ff[EV_RX_FULL];
  end

  // receive-error request covers framing and overrun
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rx_err_req_ff <= 1'b0;
    else
      rx_err_req_ff <= line_control_word_ff[RX_IRQ_ON_BIT]
                     & (event_status_ff[EV_FRAME_ERR]
                        | event_status_ff[EV_OVERRUN]);
  end

  // transmit-end request
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      tx_done_req_ff <= 1'b0;
    else
      tx_done_req_ff <= line_control_word_ff[TX_DONE_IRQ_ON_BIT]
                      & event_status_ff[EV_TX_DONE];
  end

  // summary interrupt: high while any enabled status bit is set
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(event_status_ff & event_enable_ff);
  end

  // one-cycle pulse for each character that passes the filter
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rx_accept_ff <= 1'b0;
    else
      rx_accept_ff <= rx_kept;
  end

  // clock source selection; reserved codes fall back to internal, undriven
  assign cs.sync_mode = sync_mode;
  assign cs.src_code  = {line_control_word_ff[CLK_SRC_HI_BIT],
                         line_control_word_ff[CLK_SRC_LO_BIT]};

  // selector: pin synchroniser, bit-rate clock and pin drive enable
  clock_source_select u_clock_source_select (
    .clock     (clock),
    .rst       (rst),
    .baud_tick (baud_tick),
    .pin_in    (serial_clk_pin_in),
    .cs        (cs.selector)
  );

  // bus side outputs
  assign readdata            = readdata_ff;
  assign waitrequest         = waitrequest_ff;
  // controls toward the shift core
  assign tx_run              = line_control_word_ff[TX_ON_BIT];
  assign rx_run              = line_control_word_ff[RX_ON_BIT];
  assign rx_accept           = rx_accept_ff;
  assign bit_tick            = cs.bit_tick;
  // interrupt requests
  assign tx_empty_irq        = tx_empty_req_ff;
  assign rx_full_irq         = rx_full_req_ff;
  assign rx_err_irq          = rx_err_req_ff;
  assign tx_done_irq         = tx_done_req_ff;
  assign irq                 = irq_ff;
  // serial clock pin
  assign serial_clk_pin_out  = cs.pin_out;
  assign serial_clk_pin_oe_n = cs.pin_oe_n;

endmodule : serial_port_control
`default_nettype wire

// File: verilog/serial_port_control_pkg.sv
/*
  constants shared by the serial port control block: register map, field
  positions, reset values and clock-source codes.
  assumes a 32-bit avalon-mm word-addressed view with byte addresses.
*/
package serial_port_control_pkg;

  // register byte addresses
  localparam logic [4:0] LINE_CONTROL_ADDR = 5'h00;
  localparam logic [4:0] LINE_FORMAT_ADDR  = 5'h04;
  localparam logic [4:0] EVENT_STATUS_ADDR = 5'h08;
  localparam logic [4:0] EVENT_CLEAR_ADDR  = 5'h0c;
  localparam logic [4:0] EVENT_ENABLE_ADDR = 5'h10;

  // line_control_word fields
  localparam int TX_EMPTY_IRQ_ON_BIT = 7;
  localparam int RX_IRQ_ON_BIT       = 6;
  localparam int TX_ON_BIT           = 5;
  localparam int RX_ON_BIT           = 4;
  localparam int ADDR_WAIT_ON_BIT    = 3;
  localparam int TX_DONE_IRQ_ON_BIT  = 2;
  localparam int CLK_SRC_HI_BIT      = 1;
  localparam int CLK_SRC_LO_BIT      = 0;
  localparam logic [7:0] LINE_CONTROL_RESET = 8'h00;

  // line_format_word fields
  localparam int SYNC_MODE_BIT     = 7;
  localparam int MULTI_DROP_ON_BIT = 2;
  localparam logic [7:0] LINE_FORMAT_RESET = 8'h00;

  // event status / clear / enable layout
  localparam int EV_TX_EMPTY  = 0;
  localparam int EV_RX_FULL   = 1;
  localparam int EV_FRAME_ERR = 2;
  localparam int EV_OVERRUN   = 3;
  localparam int EV_TX_DONE   = 4;
  localparam int EV_WIDTH     = 5;
  localparam logic [4:0] EVENT_RESET = 5'h00;

  // clock-source codes
  localparam logic [1:0] CLK_INTERNAL     = 2'b00;
  localparam logic [1:0] CLK_INTERNAL_OUT = 2'b01;
  localparam logic [1:0] CLK_EXTERNAL     = 2'b10;

  // internal tick runs at 16x the bit rate
  localparam int TICKS_PER_BIT = 16;
  localparam logic [3:0] HALF_BIT_TICKS = 4'h7;

endpackage : serial_port_control_pkg
